// >>> design/mac_accumulator_overflow.sv
/*
  Multiply-accumulate datapath with a one-cycle accumulator overflow pulse.
  Assumes fabric logic on core_clk supplies operands already padded to a
  native width (zero fill for unsigned, sign fill for signed) and counts the
  overflow pulses itself when it needs a wider result.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mac_consts.svh"

module mac_accumulator_overflow
  import mac_pkg::*;
#(
  parameter int ACC_W = `MAC_ACC_W   // accumulator width, not below the product width
)
(
  input  wire logic                 core_clk,      // datapath clock, 20 MHz
  input  wire logic                 resetn,        // synchronous reset, active low
  input  wire logic                 mac_en,        // accept operands this cycle
  input  wire logic                 acc_load,      // start a new sum with this product
  input  wire logic                 signed_mode,   // operands are two's complement
  input  wire width_e               op_width,      // native operand width
  input  wire logic [`MAC_W36-1:0]  op_a,          // operand a, padded to width
  input  wire logic [`MAC_W36-1:0]  op_b,          // operand b, padded to width
  output logic [ACC_W-1:0]          acc_out,       // accumulated sum
  output logic                      acc_valid,     // acc_out updated last edge
  output logic                      overflow       // one-cycle roll-over pulse
);

  logic                   prod_valid;
  logic                   prod_load;
  logic                   prod_signed;
  logic [`MAC_PROD_W-1:0] prod;

  mac_operand_mult u_mult (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .valid_in   (mac_en),
    .load_in    (acc_load),
    .signed_in  (signed_mode),
    .width_in   (op_width),
    .op_a       (op_a),
    .op_b       (op_b),
    .valid_reg  (prod_valid),
    .load_reg   (prod_load),
    .signed_reg (prod_signed),
    .prod_reg   (prod)
  );

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic             ovf_reg;
  logic             ovf_next;
  logic             valid_reg;
  logic             valid_next;
  logic [ACC_W-1:0] prod_ext;
  logic [ACC_W:0]   sum;
  logic             unsigned_wrap;
  logic             signed_wrap;

  always_comb begin
    // sign-extend in signed mode so the sum keeps two's complement meaning
    if (prod_signed) begin
      prod_ext = ACC_W'($signed(prod));
    end else begin
      prod_ext = ACC_W'(prod);
    end
    sum = {1'b0, acc_reg} + {1'b0, prod_ext};
    // carry out means the result came out smaller than an addend
    unsigned_wrap = sum[ACC_W];
    // like signs in, other sign out
    signed_wrap = (acc_reg[ACC_W-1] == prod_ext[ACC_W-1]) &&
                  (sum[ACC_W-1] != acc_reg[ACC_W-1]);
    acc_next   = acc_reg;
    ovf_next   = 1'b0;
    valid_next = prod_valid;
    if (prod_valid) begin
      if (prod_load) begin
        // a fresh sum starts from zero, so it cannot roll over
        acc_next = prod_ext;
      end else begin
        acc_next = sum[ACC_W-1:0];
        ovf_next = prod_signed ? signed_wrap : unsigned_wrap;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      acc_reg   <= `MAC_ACC_RST;
      ovf_reg   <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      acc_reg   <= acc_next;
      ovf_reg   <= ovf_next;
      valid_reg <= valid_next;
    end
  end

  assign acc_out   = acc_reg;
  assign acc_valid = valid_reg;
  assign overflow  = ovf_reg;

  // assertion helpers
  logic             add_step;

  assign add_step = prod_valid && !prod_load;

  property p_ovf_has_cause;
    @(posedge core_clk) disable iff (!resetn)
      overflow |-> $past(add_step);
  endproperty
  a_ovf_has_cause: assert property (p_ovf_has_cause) else $error("overflow without accumulate step");

  property p_unsigned_wrap;
    @(posedge core_clk) disable iff (!resetn)
      (add_step && !prod_signed) ##1 (acc_out < $past(acc_out)) |-> overflow;
  endproperty
  a_unsigned_wrap: assert property (p_unsigned_wrap) else $error("unsigned roll-over not flagged");

  property p_unsigned_nowrap;
    @(posedge core_clk) disable iff (!resetn)
      (add_step && !prod_signed) ##1 (acc_out >= $past(acc_out)) |-> !overflow;
  endproperty
  a_unsigned_nowrap: assert property (p_unsigned_nowrap) else $error("false unsigned overflow");

  property p_signed_pos;
    @(posedge core_clk) disable iff (!resetn)
      (add_step && prod_signed && !acc_reg[ACC_W-1] && !prod_ext[ACC_W-1]) ##1 acc_out[ACC_W-1]
        |-> overflow;
  endproperty
  a_signed_pos: assert property (p_signed_pos) else $error("positive roll-over not flagged");

  property p_signed_neg;
    @(posedge core_clk) disable iff (!resetn)
      (add_step && prod_signed && acc_reg[ACC_W-1] && prod_ext[ACC_W-1]) ##1 !acc_out[ACC_W-1]
        |-> overflow;
  endproperty
  a_signed_neg: assert property (p_signed_neg) else $error("negative roll-over not flagged");

  property p_signed_mixed;
    @(posedge core_clk) disable iff (!resetn)
      (add_step && prod_signed && (acc_reg[ACC_W-1] != prod_ext[ACC_W-1])) |=> !overflow;
  endproperty
  a_signed_mixed: assert property (p_signed_mixed) else $error("mixed-sign add flagged overflow");

  property p_pulse_one_cycle;
    @(posedge core_clk) disable iff (!resetn)
      (overflow && !add_step) |=> !overflow;
  endproperty
  a_pulse_one_cycle: assert property (p_pulse_one_cycle) else $error("overflow held past one cycle");

  property p_accumulate;
    @(posedge core_clk) disable iff (!resetn)
      (add_step && !prod_signed) |=> acc_out == ACC_W'($past(acc_out) + ACC_W'($past(prod)));
  endproperty
  a_accumulate: assert property (p_accumulate) else $error("accumulator not product plus sum");

  property p_hold;
    @(posedge core_clk) disable iff (!resetn)
      !prod_valid |=> $stable(acc_out) && !acc_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("accumulator moved without product");

  property p_latency;
    @(posedge core_clk) disable iff (!resetn)
      (mac_en && !acc_load) |-> ##2 acc_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("result not two cycles after operands");

  // expectations rebuild the sum from the registered product, not from the adder
  property p_accumulate_signed;
    @(posedge core_clk) disable iff (!resetn)
      (add_step && prod_signed)
        |=> acc_out == ACC_W'($past(acc_out) + ACC_W'($signed($past(prod))));
  endproperty
  a_accumulate_signed: assert property (p_accumulate_signed) else $error("signed sum wrong");

  property p_load_unsigned;
    @(posedge core_clk) disable iff (!resetn)
      (prod_valid && prod_load && !prod_signed) |=> acc_out == ACC_W'($past(prod));
  endproperty
  a_load_unsigned: assert property (p_load_unsigned) else $error("unsigned load not the product");

  property p_load_signed;
    @(posedge core_clk) disable iff (!resetn)
      (prod_valid && prod_load && prod_signed) |=> acc_out == ACC_W'($signed($past(prod)));
  endproperty
  a_load_signed: assert property (p_load_signed) else $error("signed load not the product");

  property p_load_no_ovf;
    @(posedge core_clk) disable iff (!resetn)
      (prod_valid && prod_load) |=> !overflow;
  endproperty
  a_load_no_ovf: assert property (p_load_no_ovf) else $error("load flagged overflow");

  property p_ovf_with_valid;
    @(posedge core_clk) disable iff (!resetn)
      overflow |-> acc_valid;
  endproperty
  a_ovf_with_valid: assert property (p_ovf_with_valid) else $error("overflow without a result");

  property p_valid_has_product;
    @(posedge core_clk) disable iff (!resetn)
      acc_valid |-> $past(prod_valid);
  endproperty
  a_valid_has_product: assert property (p_valid_has_product) else $error("result without product");

  property p_signed_nowrap;
    @(posedge core_clk) disable iff (!resetn)
      (add_step && prod_signed && (acc_reg[ACC_W-1] == prod_ext[ACC_W-1]))
        ##1 (acc_out[ACC_W-1] == $past(acc_out[ACC_W-1])) |-> !overflow;
  endproperty
  a_signed_nowrap: assert property (p_signed_nowrap) else $error("false signed overflow");

  property p_reset_clear;
    @(posedge core_clk)
      !resetn |=> (acc_out == `MAC_ACC_RST) && !acc_valid
        && !overflow;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state behind");

endmodule
`default_nettype wire

// >>> design/mac_consts.svh
/*
  Constants of the multiply-accumulate datapath: native operand widths,
  product and accumulator widths, reset values and pipeline latency.
  Assumes inclusion by its bare name from the datapath package and modules.
*/
`ifndef MAC_CONSTS_SVH
`define MAC_CONSTS_SVH

`define MAC_W9       9
`define MAC_W18      18
`define MAC_W36      36
`define MAC_PROD_W   72
`define MAC_ACC_W    72
`define MAC_ACC_RST  72'h0000_0000_0000_0000_00
`define MAC_MULT_LAT 1

`endif

// >>> design/mac_operand_mult.sv
/*
  Native-width operand multiplier with one register stage.
  Assumes operands arrive already padded to the selected native width by
  the fabric; bits above the selected width are ignored and re-extended.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mac_consts.svh"

module mac_operand_mult
  import mac_pkg::*;
(
  input  wire logic                     core_clk,    // datapath clock
  input  wire logic                     resetn,      // synchronous reset, active low
  input  wire logic                     valid_in,    // operands valid this cycle
  input  wire logic                     load_in,     // load rather than accumulate
  input  wire logic                     signed_in,   // operands are two's complement
  input  wire width_e                   width_in,    // native operand width
  input  wire logic [`MAC_W36-1:0]      op_a,        // operand a
  input  wire logic [`MAC_W36-1:0]      op_b,        // operand b
  output logic                          valid_reg,   // product valid
  output logic                          load_reg,    // load flag aligned to product
  output logic                          signed_reg,  // signed flag aligned to product
  output logic [`MAC_PROD_W-1:0]        prod_reg     // registered product
);

  // bits above the native width are rebuilt here, so stray upper bits are harmless
  function automatic logic [`MAC_W36-1:0] native_op(input logic [`MAC_W36-1:0] op,
                                                   input width_e w, input logic sgn);
    logic fill;
    fill = 1'b0;
    case (w)
      WIDTH_X9: begin
        fill = sgn & op[`MAC_W9-1];
        native_op = {{(`MAC_W36-`MAC_W9){fill}}, op[`MAC_W9-1:0]};
      end
      WIDTH_X18: begin
        fill = sgn & op[`MAC_W18-1];
        native_op = {{(`MAC_W36-`MAC_W18){fill}}, op[`MAC_W18-1:0]};
      end
      default: begin
        native_op = op;
      end
    endcase
  endfunction

  logic [`MAC_W36-1:0]   a_nat;
  logic [`MAC_W36-1:0]   b_nat;
  logic [`MAC_W36*2+1:0] prod_full;
  logic                  valid_next;
  logic                  load_next;
  logic                  signed_next;
  logic [`MAC_PROD_W-1:0] prod_next;

  always_comb begin
    a_nat       = native_op(op_a, width_in, signed_in);
    b_nat       = native_op(op_b, width_in, signed_in);
    // one extra bit per operand lets one signed multiplier serve both modes
    prod_full   = $signed({signed_in & a_nat[`MAC_W36-1], a_nat}) *
                  $signed({signed_in & b_nat[`MAC_W36-1], b_nat});
    valid_next  = valid_in;
    load_next   = valid_in & load_in;
    signed_next = valid_in ? signed_in : signed_reg;
    prod_next   = valid_in ? prod_full[`MAC_PROD_W-1:0] : prod_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      valid_reg  <= 1'b0;
      load_reg   <= 1'b0;
      signed_reg <= 1'b0;
      prod_reg   <= '0;
    end else begin
      valid_reg  <= valid_next;
      load_reg   <= load_next;
      signed_reg <= signed_next;
      prod_reg   <= prod_next;
    end
  end

  property p_x9_unsigned_range;
    @(posedge core_clk) disable iff (!resetn)
      (valid_in && !signed_in && width_in == WIDTH_X9) |=> (prod_reg >> (2*`MAC_W9)) == '0;
  endproperty
  a_x9_unsigned_range: assert property (p_x9_unsigned_range) else $error("x9 unsigned product too wide");

  property p_x18_signed_small;
    @(posedge core_clk) disable iff (!resetn)
      (valid_in && signed_in && width_in == WIDTH_X18 && op_a[`MAC_W18-1:0] == 18'h0_0001)
        |=> prod_reg == `MAC_PROD_W'($signed($past(op_b[`MAC_W18-1:0])));
  endproperty
  a_x18_signed_small: assert property (p_x18_signed_small) else $error("x18 signed extension wrong");

endmodule
`default_nettype wire

// >>> design/mac_pkg.sv
/*
  Types shared by the multiply-accumulate datapath modules.
  Assumes mac_consts.svh sits beside it.
*/
`include "mac_consts.svh"

package mac_pkg;
  typedef enum logic [1:0] {
    WIDTH_X9,
    WIDTH_X18,
    WIDTH_X36
  } width_e;
endpackage

// >>> verif/mac_accumulator_overflow_tb_top.sv
/*
  Self-checking bench for the multiply-accumulate datapath with overflow pulse.
  Assumes the fabric model pads operands and that results land one edge after
  the accepting edge.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mac_consts.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end

module mac_accumulator_overflow_tb_top
  import mac_pkg::*;
;
  logic         core_clk, resetn, mac_en, acc_load, signed_mode, acc_valid, overflow;
  width_e       op_width;
  logic [5:0]   raw_bits;
  logic [35:0]  raw_a, raw_b, op_a, op_b;
  logic [71:0]  acc_out, exp_acc;
  logic [72:0]  e;
  logic [72:0]  exp_q[$];
  logic [15:0]  ovf_count, exp_ovf;
  int           bad_count, n_tests, cyc, nb;
  width_e       w;

  mac_accumulator_overflow #(.ACC_W(72)) dut (.core_clk(core_clk), .resetn(resetn), .mac_en(mac_en),
    .acc_load(acc_load), .signed_mode(signed_mode), .op_width(op_width), .op_a(op_a), .op_b(op_b),
    .acc_out(acc_out), .acc_valid(acc_valid), .overflow(overflow));
  mac_fabric_model fab (.core_clk(core_clk), .resetn(resetn), .signed_mode(signed_mode),
    .raw_bits(raw_bits), .raw_a(raw_a), .raw_b(raw_b), .overflow(overflow),
    .pad_a(op_a), .pad_b(op_b), .ovf_count(ovf_count));

  always #25 core_clk = ~core_clk;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [35:0] rnd36();
    logic [63:0] t;
    t = {$urandom, $urandom};
    return t[35:0];
  endfunction

  // widen the true operand value independently of the fabric padding
  function automatic logic [71:0] ext(input logic [35:0] v, input int n, input logic s);
    logic [71:0] x;
    x = {36'h0_0000_0000, v} << (72 - n);
    return s ? 72'($signed(x) >>> (72 - n)) : (x >> (72 - n));
  endfunction

  task automatic do_op(input logic ld, input logic sg, input width_e wd, input int n,
                       input logic [35:0] a, input logic [35:0] b);
    logic [71:0] pr, sum;
    logic        ov;
    pr = ext(a, n, sg) * ext(b, n, sg);
    sum = ld ? pr : exp_acc + pr;
    ov = ld ? 1'b0 : (sg ? (exp_acc[71] == pr[71] && sum[71] != exp_acc[71]) : (sum < exp_acc));
    exp_acc = sum;
    exp_q.push_back({ov, sum});
    exp_ovf += {15'h0000, ov};
    raw_a <= a;
    raw_b <= b;
    raw_bits <= 6'(n);
    mac_en <= 1'b1;
    acc_load <= ld;
    signed_mode <= sg;
    op_width <= wd;
    @(posedge core_clk);
  endtask

  task automatic idle();
    mac_en <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic drain();
    idle();
    for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    `CHK(exp_q.size(), 0)
    `CHK(ovf_count, exp_ovf)
  endtask

  // results are checked where they settle, away from the launching edge
  always @(negedge core_clk) begin
    if (resetn === 1'b1) begin
      if (acc_valid === 1'b1) begin
        if (exp_q.size() == 0) begin
          bad_count++;
          $display("[ERR] %0t result with nothing pending", $time);
        end else begin
          e = exp_q.pop_front();
          `CHK(acc_out, e[71:0])
          `CHK(overflow, e[72])
        end
      end else `CHK(overflow, 1'b0)
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    core_clk = 0; resetn = 0; mac_en = 0; acc_load = 0; signed_mode = 0; op_width = WIDTH_X9;
    raw_a = 0; raw_b = 0; raw_bits = 6'd9; exp_acc = 0; exp_ovf = 0;
    bad_count = 0; n_tests = 0; cyc = 0;
    void'($urandom(99));
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 36; i++) begin
      w = width_e'(i % 3);
      nb = (w == WIDTH_X9) ? 9 : (w == WIDTH_X18) ? 18 : 36;
      nb = 2 + ($urandom % (nb - 1));
      do_op(i % 12 == 0, i >= 18, w, nb, rnd36(), rnd36());
      if (i % 5 == 4) idle();
    end
    $display("test random widths done");
    do_op(1, 0, WIDTH_X36, 36, 36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF);
    repeat (2) do_op(0, 0, WIDTH_X36, 36, 36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF);
    $display("test unsigned wrap done");
    do_op(1, 1, WIDTH_X36, 36, 36'h8_0000_0000, 36'h8_0000_0000);
    do_op(0, 1, WIDTH_X36, 36, 36'h8_0000_0000, 36'h8_0000_0000);
    do_op(1, 1, WIDTH_X36, 36, 36'h7_FFFF_FFFF, 36'h8_0000_0000);
    repeat (3) do_op(0, 1, WIDTH_X36, 36, 36'h7_FFFF_FFFF, 36'h8_0000_0000);
    do_op(0, 1, WIDTH_X9, 4, 36'h0_0000_000A, 36'h0_0000_0005);
    // unity operand reaches the x18 sign-extension check; code 3 must act as x36
    do_op(1, 1, WIDTH_X18, 18, 36'h0_0000_0001, rnd36());
    do_op(0, 0, width_e'(2'h3), 36, rnd36(), rnd36());
    drain();
    $display("test signed roll-over done");
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(acc_out, 72'h0000_0000_0000_0000_00)
    `CHK({acc_valid, overflow}, 2'h0)
    exp_acc = 0;
    exp_ovf = 0;
    resetn <= 1'b1;
    repeat (2) do_op(0, 0, WIDTH_X36, 36, 36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF);
    drain();
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule

`default_nettype wire

// >>> verif/mac_fabric_model.sv
/*
  Fabric-side partner of the multiply-accumulate datapath: pads narrow
  operands up to a native width and counts overflow pulses as upper sum bits.
  Assumes the same core_clk and resetn as the datapath.
*/
`timescale 1ns/100ps
`default_nettype none

module mac_fabric_model (
  input  wire logic        core_clk,     // datapath clock
  input  wire logic        resetn,       // synchronous reset, active low
  input  wire logic        signed_mode,  // operands are two's complement
  input  wire logic [5:0]  raw_bits,     // true operand width, 2 to 36
  input  wire logic [35:0] raw_a,        // narrow operand a
  input  wire logic [35:0] raw_b,        // narrow operand b
  input  wire logic        overflow,     // roll-over pulse from the datapath
  output logic [35:0]      pad_a,        // operand a padded to 36 bits
  output logic [35:0]      pad_b,        // operand b padded to 36 bits
  output logic [15:0]      ovf_count     // upper bits of a wider sum
);
  function automatic logic [35:0] pad(input logic [35:0] v, input logic [5:0] n, input logic s);
    logic [35:0] r;
    for (int i = 0; i < 36; i++) begin
      r[i] = (i < n) ? v[i] : (s & v[n-1]);
    end
    return r;
  endfunction

  always_comb begin
    pad_a = pad(raw_a, raw_bits, signed_mode);
    pad_b = pad(raw_b, raw_bits, signed_mode);
  end

  // one count per cycle high, since each pulse lasts a single cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) ovf_count <= 16'h0000;
    else if (overflow) ovf_count <= ovf_count + 16'h0001;
  end
endmodule

`default_nettype wire
